// >>> gcs_host_model.sv
/*
  Far-side model: register host on the link handshake plus the charger
  that can pull the shared pin low. Assumes a free-running link_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module gcs_host_model (
  input wire logic core_clk,
  input wire logic link_clk,
  output logic link_wr,
  output logic link_rd,
  output logic link_ara,
  output logic [gcs_pkg::ADDR_W-1:0] link_addr,
  output logic [gcs_pkg::DATA_W-1:0] link_wdata,
  input wire logic [gcs_pkg::DATA_W-1:0] link_rdata,
  input wire logic link_done,
  output logic charger_pull_low,
  output logic hung
);
  import gcs_pkg::*;
  initial begin
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_ara = 1'b0;
    link_addr = 4'h0;
    link_wdata = 16'h0;
    charger_pull_low = 1'b0;
    hung = 1'b0;
  end
  // One-cycle request pulse, then wait for done under a bound
  task automatic xfer(input gcs_kind_e kind, input logic [3:0] a, input logic [15:0] d,
                      output logic [15:0] q);
    int n;
    @(posedge link_clk);
    #2;
    link_wr = (kind == GCS_KIND_WR);
    link_rd = (kind == GCS_KIND_RD);
    link_ara = (kind == GCS_KIND_ARA);
    link_addr = a;
    link_wdata = d;
    @(posedge link_clk);
    #2;
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_ara = 1'b0;
    // Released lines carry garbage so a late sample cannot pass by luck
    link_addr = ~a;
    link_wdata = ~d;
    n = 0;
    while (link_done !== 1'b1 && n < 64) begin
      @(posedge link_clk);
      #2;
      n++;
    end
    hung = hung | (n >= 64);
    q = link_rdata;
  endtask
  task automatic charger(input logic low);
    @(posedge core_clk);
    #2;
    charger_pull_low = low;
  endtask
endmodule  // gcs_host_model
`default_nettype wire

// >>> gcs_link_bridge.sv
/*
  Toggle handshake carrying register and alert-response requests from the
  link clock domain into the core domain and read data back.
  Assumes link requests are single-cycle pulses on link_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module gcs_link_bridge
  import gcs_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic link_ara,
  input wire logic [gcs_pkg::ADDR_W-1:0] link_addr,
  input wire logic [gcs_pkg::DATA_W-1:0] link_wdata,
  output logic [gcs_pkg::DATA_W-1:0] link_rdata,
  output logic link_busy,
  output logic link_done,
  gcs_req_if.bridge req
);
  import gcs_pkg::*;

  logic lrst_s1_r, lrst_n_r;
  gcs_kind_e kind_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r, hold_rdata_r;
  logic req_t_r, ack_t_r;
  logic req_s1_r, req_s2_r, req_s3_r;
  logic ack_s1_r, ack_s2_r, ack_s3_r;
  logic req_edge, ack_edge;

  //////////////////////////////////////////////////////////////////////////
  // Link domain
  always_ff @(posedge link_clk) begin
    lrst_s1_r <= rst_n;
    lrst_n_r <= lrst_s1_r;
  end

  always_ff @(posedge link_clk) begin
    ack_s1_r <= ack_t_r;
    ack_s2_r <= ack_s1_r;
    ack_s3_r <= ack_s2_r;
  end
  assign ack_edge = ack_s2_r ^ ack_s3_r;

  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      kind_r <= GCS_KIND_WR;
      addr_r <= '0;
      wdata_r <= '0;
      req_t_r <= 1'b0;
      link_busy <= 1'b0;
    end else if (!link_busy && (link_wr || link_rd || link_ara)) begin
      kind_r <= link_wr ? GCS_KIND_WR : (link_rd ? GCS_KIND_RD : GCS_KIND_ARA);
      addr_r <= link_addr;
      wdata_r <= link_wdata;
      req_t_r <= ~req_t_r;
      link_busy <= 1'b1;
    end else if (ack_edge) begin
      link_busy <= 1'b0;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_n_r) begin
      link_rdata <= '0;
      link_done <= 1'b0;
    end else begin
      link_done <= ack_edge;
      if (ack_edge) begin
        link_rdata <= hold_rdata_r;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Core domain; kind, address and data stay still until the ack returns
  always_ff @(posedge core_clk) begin
    req_s1_r <= req_t_r;
    req_s2_r <= req_s1_r;
    req_s3_r <= req_s2_r;
  end
  assign req_edge = req_s2_r ^ req_s3_r;

  assign req.wr_stb = req_edge && (kind_r == GCS_KIND_WR);
  assign req.rd_stb = req_edge && (kind_r == GCS_KIND_RD);
  assign req.ara_stb = req_edge && (kind_r == GCS_KIND_ARA);
  assign req.addr = addr_r;
  assign req.wdata = wdata_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      hold_rdata_r <= '0;
      ack_t_r <= 1'b0;
    end else if (req_edge) begin
      hold_rdata_r <= req.rdata;
      ack_t_r <= ~ack_t_r;
    end
  end

endmodule // gcs_link_bridge
`default_nettype wire

// >>> gcs_pkg.sv
/*
  Shared constants of the gauge control sequencer: register map, control
  and status field layout, reset values, modes and conversion timing.
  Assumes a 25 MHz core clock.
*/
package gcs_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  ////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_ACC = 4'h2;
  localparam logic [3:0] REG_VOLT = 4'h3;
  localparam logic [3:0] REG_CUR = 4'h4;
  localparam logic [3:0] REG_TEMP = 4'h5;
  // Thresholds 8..f: charge hi/lo, voltage hi/lo, current hi/lo, temp hi/lo
  localparam logic [3:0] REG_THR_BASE = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Control fields
  localparam int CTRL_MODE_LO = 6;
  localparam int CTRL_PRE_LO = 3;
  localparam int CTRL_PIN_LO = 1;
  localparam int CTRL_SHDN = 0;
  localparam logic [7:0] CTRL_RESET = 8'h3c;

  typedef enum logic [1:0] {
    GCS_MODE_SLEEP = 2'b00,
    GCS_MODE_MANUAL = 2'b01,
    GCS_MODE_SCAN = 2'b10,
    GCS_MODE_AUTO = 2'b11
  } gcs_mode_e;

  localparam logic [1:0] PIN_OFF = 2'b00;
  localparam logic [1:0] PIN_CHG_DONE = 2'b01;
  localparam logic [1:0] PIN_ALERT = 2'b10;

  ////////////////////////////////////////////////////////////////////////
  // Status fields
  localparam int ST_UVLO = 0;
  localparam int ST_VOLT = 1;
  localparam int ST_CHG_LO = 2;
  localparam int ST_CHG_HI = 3;
  localparam int ST_TEMP = 4;
  localparam int ST_OVF = 5;
  localparam int ST_CUR = 6;
  localparam logic [7:0] STATUS_RESET = 8'h01;

  localparam logic [15:0] ACC_RESET = 16'h7fff;
  localparam logic [15:0] ACC_FULL = 16'hffff;
  localparam logic [15:0] THR_HI_RESET = 16'hffff;
  localparam logic [15:0] THR_LO_RESET = 16'h0000;

  ////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int VOLT_CONV_US = 33000;
  localparam int CT_CONV_US = 4500;
  localparam int SCAN_IDLE_US = 10000000;
  localparam int VOLT_CONV_CYC = VOLT_CONV_US * CLK_MHZ;
  localparam int CT_CONV_CYC = CT_CONV_US * CLK_MHZ;
  localparam int SCAN_IDLE_CYC = SCAN_IDLE_US * CLK_MHZ;
  localparam int TIME_W = 28;

  typedef enum logic [2:0] {
    GCS_SEQ_IDLE = 3'b000,
    GCS_SEQ_VOLT = 3'b001,
    GCS_SEQ_CURR = 3'b011,
    GCS_SEQ_TEMP = 3'b010,
    GCS_SEQ_WAIT = 3'b110
  } gcs_seq_e;

  localparam logic [1:0] SEL_VOLT = 2'd0;
  localparam logic [1:0] SEL_CUR = 2'd1;
  localparam logic [1:0] SEL_TEMP = 2'd2;

  typedef enum logic [1:0] {
    GCS_KIND_WR = 2'b00,
    GCS_KIND_RD = 2'b01,
    GCS_KIND_ARA = 2'b10
  } gcs_kind_e;

endpackage

// >>> gcs_req_if.sv
/*
  Core-side request carrier between the link bridge and the sequencer core.
  All signals but addr and wdata belong to the core clock domain; those two come from link_clk registers.
*/
`timescale 1ns/1ns
`default_nettype none
interface gcs_req_if;
  import gcs_pkg::*;
  logic wr_stb;
  logic rd_stb;
  logic ara_stb;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  modport bridge (output wr_stb, output rd_stb, output ara_stb, output addr,
                  output wdata, input rdata);
  modport core (input wr_stb, input rd_stb, input ara_stb, input addr,
                input wdata, output rdata);
endinterface
`default_nettype wire

// >>> gcs_seq_props.sv
/*
  Checker for the gauge control sequencer, watching its top ports only.
  Assumes it is bound into gcs_sequencer; every check runs on core_clk.
*/
`timescale 1ns/1ns
`default_nettype none
module gcs_seq_props #(
  parameter int VOLT_CYC = 40,
  parameter int CT_CYC = 10,
  parameter int IDLE_CYC = 20
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_busy,
  input wire logic alert_or_charge_done_pin_out,
  input wire logic alert_or_charge_done_pin_oe,
  input wire logic adc_run,
  input wire logic [1:0] adc_sel
);
  import gcs_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////
  logic run_r;
  logic [1:0] sel_r;
  int cnt_r;
  logic seg_end;
  // Segment ends when the run stops or the converted quantity changes
  assign seg_end = run_r && (!adc_run || adc_sel != sel_r);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      sel_r <= 2'd0;
    end else begin
      run_r <= adc_run;
      sel_r <= adc_sel;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n || !adc_run) begin
      cnt_r <= 0;
    end else if (adc_sel != sel_r) begin
      cnt_r <= 1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  chk_open_drain: assert property (
    !alert_or_charge_done_pin_out) else $error("shared pin driven high");
  chk_volt_length: assert property (
    seg_end && sel_r == SEL_VOLT |-> cnt_r >= VOLT_CYC - 1 && cnt_r <= VOLT_CYC + 1)
    else $error("voltage conversion length wrong");
  chk_cur_length: assert property (
    seg_end && sel_r == SEL_CUR |-> cnt_r >= CT_CYC - 1 && cnt_r <= CT_CYC + 1)
    else $error("current conversion length wrong");
  chk_temp_length: assert property (
    seg_end && sel_r == SEL_TEMP |-> cnt_r >= CT_CYC - 1 && cnt_r <= CT_CYC + 1)
    else $error("temperature conversion length wrong");
  chk_start_volt: assert property (
    $rose(adc_run) |-> adc_sel == SEL_VOLT) else $error("cycle not started with voltage");
  chk_step_order: assert property (
    adc_run && run_r && adc_sel != sel_r |->
      adc_sel == sel_r + 2'd1 || (sel_r == SEL_TEMP && adc_sel == SEL_VOLT))
    else $error("conversion order broken");
  chk_cycle_whole: assert property (
    $fell(adc_run) |-> sel_r == SEL_TEMP) else $error("cycle stopped before temperature");
  chk_alert_release: assert property (
    $fell(alert_or_charge_done_pin_oe) |-> link_busy)
    else $error("alert released without alert response");
endmodule  // gcs_seq_props

bind gcs_sequencer gcs_seq_props #(.VOLT_CYC(VOLT_CYC), .CT_CYC(CT_CYC), .IDLE_CYC(IDLE_CYC))
  chk_u (.core_clk(core_clk), .rst_n(rst_n), .link_busy(link_busy), .adc_run(adc_run),
    .alert_or_charge_done_pin_out(alert_or_charge_done_pin_out),
    .alert_or_charge_done_pin_oe(alert_or_charge_done_pin_oe), .adc_sel(adc_sel));
`default_nettype wire

// >>> gcs_sequencer.sv
/*
  Gauge control sequencer: control/status registers, conversion sequencer,
  coulomb prescaler and accumulator, thresholds and the shared alert or
  charge-complete pin. Assumes an external converter returning results on
  adc_result and an analog integrator giving up/down steps on pins.
*/
`timescale 1ns/1ns
`default_nettype none
module gcs_sequencer
  import gcs_pkg::*;
#(
  parameter int VOLT_CYC = gcs_pkg::VOLT_CONV_CYC,
  parameter int CT_CYC = gcs_pkg::CT_CONV_CYC,
  parameter int IDLE_CYC = gcs_pkg::SCAN_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic link_wr,
  input wire logic link_rd,
  input wire logic link_ara,
  input wire logic [gcs_pkg::ADDR_W-1:0] link_addr,
  input wire logic [gcs_pkg::DATA_W-1:0] link_wdata,
  output logic [gcs_pkg::DATA_W-1:0] link_rdata,
  output logic link_busy,
  output logic link_done,
  input wire logic alert_or_charge_done_pin_in,
  output logic alert_or_charge_done_pin_out,
  output logic alert_or_charge_done_pin_oe,
  input wire logic chg_up_pin,
  input wire logic chg_dn_pin,
  input wire logic [gcs_pkg::DATA_W-1:0] adc_result,
  output logic adc_run,
  output logic [1:0] adc_sel,
  output logic analog_shdn
);
  import gcs_pkg::*;

  if (VOLT_CYC < 1 || CT_CYC < 1 || IDLE_CYC < 1 ||
      VOLT_CYC >= (1 << TIME_W) || CT_CYC >= (1 << TIME_W) ||
      IDLE_CYC >= (1 << TIME_W)) begin : g_bad_timing
    $error("gcs_sequencer: timing parameter out of range");
  end

  gcs_req_if req ();

  gcs_link_bridge u_bridge (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .link_clk(link_clk),
    .link_wr(link_wr),
    .link_rd(link_rd),
    .link_ara(link_ara),
    .link_addr(link_addr),
    .link_wdata(link_wdata),
    .link_rdata(link_rdata),
    .link_busy(link_busy),
    .link_done(link_done),
    .req(req)
  );

  logic [7:0] ctrl_r;
  logic [7:0] status_r, st_set;
  logic [15:0] acc_r;
  logic [15:0] res_r [0:2];
  logic [15:0] thr_r [0:7];
  gcs_seq_e state_r, state_nxt;
  logic [TIME_W-1:0] timer_r, timer_nxt;
  logic conv_done, manual_clear, alert_r;
  logic [1:0] q;
  gcs_mode_e mode;
  logic [1:0] pin_cfg;
  logic shdn;

  assign mode = gcs_mode_e'(ctrl_r[CTRL_MODE_LO +: 2]);
  assign pin_cfg = ctrl_r[CTRL_PIN_LO +: 2];
  assign shdn = ctrl_r[CTRL_SHDN];

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic pin_s1_r, pin_s2_r;
  logic up_s1_r, up_s2_r, up_s3_r;
  logic dn_s1_r, dn_s2_r, dn_s3_r;
  logic up_step, dn_step;

  always_ff @(posedge core_clk) begin
    pin_s1_r <= alert_or_charge_done_pin_in;
    pin_s2_r <= pin_s1_r;
    up_s1_r <= chg_up_pin;
    up_s2_r <= up_s1_r;
    up_s3_r <= up_s2_r;
    dn_s1_r <= chg_dn_pin;
    dn_s2_r <= dn_s1_r;
    dn_s3_r <= dn_s2_r;
  end
  assign up_step = up_s2_r && !up_s3_r;
  assign dn_step = dn_s2_r && !dn_s3_r;

  //////////////////////////////////////////////////////////////////////////
  // Control register
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RESET;
    end else if (req.wr_stb && req.addr == REG_CONTROL) begin
      ctrl_r <= req.wdata[7:0];
    end else if (manual_clear) begin
      ctrl_r[CTRL_MODE_LO +: 2] <= GCS_MODE_SLEEP;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Conversion sequencer
  assign conv_done = (timer_r == '0) && (state_r == GCS_SEQ_VOLT ||
                     state_r == GCS_SEQ_CURR || state_r == GCS_SEQ_TEMP);
  assign manual_clear = conv_done && state_r == GCS_SEQ_TEMP &&
                        mode == GCS_MODE_MANUAL;

  always_comb begin
    state_nxt = state_r;
    timer_nxt = (timer_r == '0) ? timer_r : timer_r - 1'b1;
    unique case (state_r)
      GCS_SEQ_IDLE: begin
        if (mode != GCS_MODE_SLEEP && !shdn) begin
          state_nxt = GCS_SEQ_VOLT;
          timer_nxt = TIME_W'(VOLT_CYC - 1);
        end
      end
      GCS_SEQ_VOLT: begin
        if (timer_r == '0) begin
          state_nxt = GCS_SEQ_CURR;
          timer_nxt = TIME_W'(CT_CYC - 1);
        end
      end
      GCS_SEQ_CURR: begin
        if (timer_r == '0) begin
          state_nxt = GCS_SEQ_TEMP;
          timer_nxt = TIME_W'(CT_CYC - 1);
        end
      end
      GCS_SEQ_TEMP: begin
        if (timer_r == '0) begin
          if (mode == GCS_MODE_SCAN) begin
            state_nxt = GCS_SEQ_WAIT;
            timer_nxt = TIME_W'(IDLE_CYC - 1);
          end else if (mode == GCS_MODE_AUTO && !shdn) begin
            state_nxt = GCS_SEQ_VOLT;
            timer_nxt = TIME_W'(VOLT_CYC - 1);
          end else begin
            state_nxt = GCS_SEQ_IDLE;
          end
        end
      end
      GCS_SEQ_WAIT: begin
        if (mode != GCS_MODE_SCAN) begin
          state_nxt = GCS_SEQ_IDLE;
        end else if (timer_r == '0) begin
          state_nxt = shdn ? GCS_SEQ_IDLE : GCS_SEQ_VOLT;
          timer_nxt = TIME_W'(VOLT_CYC - 1);
        end
      end
      default: begin
        state_nxt = GCS_SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= GCS_SEQ_IDLE;
      timer_r <= '0;
    end else begin
      state_r <= state_nxt;
      timer_r <= timer_nxt;
    end
  end

  always_comb begin
    unique case (state_r)
      GCS_SEQ_CURR: q = SEL_CUR;
      GCS_SEQ_TEMP: q = SEL_TEMP;
      default: q = SEL_VOLT;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      adc_run <= 1'b0;
      adc_sel <= SEL_VOLT;
      analog_shdn <= 1'b0;
    end else begin
      adc_run <= state_nxt == GCS_SEQ_VOLT || state_nxt == GCS_SEQ_CURR ||
                 state_nxt == GCS_SEQ_TEMP;
      adc_sel <= state_nxt == GCS_SEQ_CURR ? SEL_CUR :
                 (state_nxt == GCS_SEQ_TEMP ? SEL_TEMP : SEL_VOLT);
      analog_shdn <= shdn;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Results and thresholds
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      res_r[0] <= '0;
      res_r[1] <= '0;
      res_r[2] <= '0;
    end else if (conv_done) begin
      res_r[q] <= adc_result;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_thr
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          thr_r[gi] <= (gi % 2 == 0) ? THR_HI_RESET : THR_LO_RESET;
        end else if (req.wr_stb && req.addr == (REG_THR_BASE | 4'(gi))) begin
          thr_r[gi] <= req.wdata;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Coulomb prescaler and accumulator
  logic signed [13:0] pre_r, pre_nxt, pre_lim;
  logic [2:0] pre_k;
  logic acc_inc, acc_dec;
  logic [15:0] acc_step;

  // Codes above 6 saturate at the 4096 ceiling; 1 <<< 14 would wrap to 0
  assign pre_k = (ctrl_r[CTRL_PRE_LO +: 3] > 3'd6) ? 3'd6 : ctrl_r[CTRL_PRE_LO +: 3];
  assign pre_lim = 14'sd1 <<< {pre_k, 1'b0};

  always_comb begin
    pre_nxt = pre_r + (up_step ? 14'sd1 : 14'sd0) - (dn_step ? 14'sd1 : 14'sd0);
    acc_inc = 1'b0;
    acc_dec = 1'b0;
    if (shdn) begin
      pre_nxt = '0;
    end else if (pre_nxt >= pre_lim) begin
      acc_inc = 1'b1;
      pre_nxt = '0;
    end else if (pre_nxt <= -pre_lim) begin
      acc_dec = 1'b1;
      pre_nxt = '0;
    end
  end
  assign acc_step = acc_inc ? acc_r + 16'h0001 : acc_r - 16'h0001;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      acc_r <= ACC_RESET;
    end else if (pin_cfg == PIN_CHG_DONE && !pin_s2_r) begin
      acc_r <= ACC_FULL;
    end else if (req.wr_stb && req.addr == REG_ACC) begin
      acc_r <= req.wdata;
    end else if (acc_inc || acc_dec) begin
      acc_r <= acc_step;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status flags
  always_comb begin
    st_set = '0;
    if (conv_done && (adc_result > thr_r[2 + 2 * q] ||
        adc_result < thr_r[3 + 2 * q])) begin
      unique case (q)
        SEL_CUR: st_set[ST_CUR] = 1'b1;
        SEL_TEMP: st_set[ST_TEMP] = 1'b1;
        default: st_set[ST_VOLT] = 1'b1;
      endcase
    end
    if (acc_inc || acc_dec) begin
      st_set[ST_OVF] = acc_inc ? (acc_r == 16'hffff) : (acc_r == 16'h0000);
      st_set[ST_CHG_HI] = acc_step > thr_r[0];
      st_set[ST_CHG_LO] = acc_step < thr_r[1];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      status_r <= STATUS_RESET;
    end else if (req.rd_stb && req.addr == REG_STATUS) begin
      status_r <= st_set;
    end else begin
      status_r <= status_r | st_set;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Alert pin
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_r <= 1'b0;
    end else if (pin_cfg == PIN_ALERT && st_set != '0) begin
      alert_r <= 1'b1;
    end else if (req.ara_stb) begin
      alert_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe <= 1'b0;
    end else begin
      alert_or_charge_done_pin_out <= 1'b0;
      alert_or_charge_done_pin_oe <= alert_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    req.rdata = '0;
    if (req.addr[3]) begin
      req.rdata = thr_r[req.addr[2:0]];
    end else begin
      unique case (req.addr)
        REG_STATUS: req.rdata = {8'h00, status_r};
        REG_CONTROL: req.rdata = {8'h00, ctrl_r};
        REG_ACC: req.rdata = acc_r;
        REG_VOLT: req.rdata = res_r[0];
        REG_CUR: req.rdata = res_r[1];
        REG_TEMP: req.rdata = res_r[2];
        default: req.rdata = '0;
      endcase
    end
  end

endmodule // gcs_sequencer
`default_nettype wire

// >>> tb_top.sv
/*
  Self-checking bench for the gauge control sequencer.
  Assumes the host model on the link and shortened conversion counts.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import gcs_pkg::*;
  localparam int VC = 40;
  localparam int CC = 10;
  localparam int IC = 20;
  logic core_clk, link_clk, rst_n, link_wr, link_rd, link_ara, link_busy, link_done;
  logic hung, pin_in, pin_out, pin_oe, chg_low, chg_up_pin, chg_dn_pin, adc_run, analog_shdn;
  logic [3:0] link_addr;
  logic [15:0] link_wdata, link_rdata, adc_result;
  logic [1:0] adc_sel;
  int miscompares = 0;
  int check_count = 0;
  // Pulled-up open-drain wire: low when either side pulls it
  assign pin_in = (pin_oe || chg_low) ? 1'b0 : 1'b1;
  gcs_sequencer #(.VOLT_CYC(VC), .CT_CYC(CC), .IDLE_CYC(IC)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .link_clk(link_clk), .link_wr(link_wr),
    .link_rd(link_rd), .link_ara(link_ara), .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .link_busy(link_busy), .link_done(link_done),
    .alert_or_charge_done_pin_in(pin_in), .alert_or_charge_done_pin_out(pin_out),
    .alert_or_charge_done_pin_oe(pin_oe), .chg_up_pin(chg_up_pin), .chg_dn_pin(chg_dn_pin),
    .adc_result(adc_result), .adc_run(adc_run), .adc_sel(adc_sel), .analog_shdn(analog_shdn));
  gcs_host_model host_u (
    .core_clk(core_clk), .link_clk(link_clk), .link_wr(link_wr), .link_rd(link_rd),
    .link_ara(link_ara), .link_addr(link_addr), .link_wdata(link_wdata),
    .link_rdata(link_rdata), .link_done(link_done), .charger_pull_low(chg_low), .hung(hung));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      #62 link_clk = ~link_clk;
      #63 link_clk = ~link_clk;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    chk({15'h0, got}, {15'h0, exp});
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    chkb(a == REG_CONTROL && d[CTRL_PIN_LO +: 2] == 2'b11, 1'b0);
    host_u.xfer(GCS_KIND_WR, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    logic [15:0] q;
    host_u.xfer(GCS_KIND_RD, a, 16'h0, q);
    chk(q, exp);
  endtask
  task automatic wrun(input logic v, output int n);
    n = 0;
    while (adc_run !== v && n < 3000) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    chkb(n >= 3000, 1'b0);
  endtask
  task automatic pulse(input logic up, input int cnt);
    repeat (cnt) begin
      @(posedge core_clk);
      #2;
      chg_up_pin = up;
      chg_dn_pin = !up;
      repeat (3) @(posedge core_clk);
      #2;
      chg_up_pin = 1'b0;
      chg_dn_pin = 1'b0;
      repeat (3) @(posedge core_clk);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(REG_CONTROL, 16'h003c);
    rd(REG_ACC, 16'h7fff);
    rd(4'h6, 16'h0000);
    chkb(adc_run, 1'b0);
    chkb(analog_shdn, 1'b0);
  endtask
  task automatic t_manual();
    logic [15:0] q;
    int n;
    @(posedge core_clk);
    #2;
    adc_result = 16'h2000;
    wr(REG_THR_BASE + 4'h2, 16'h1000);
    wr(REG_THR_BASE + 4'h5, 16'h3000);
    wr(REG_CONTROL, 16'h007c);
    wrun(1'b1, n);
    wrun(1'b0, n);
    chkb(pin_oe, 1'b1);
    rd(REG_VOLT, 16'h2000);
    rd(REG_CUR, 16'h2000);
    rd(REG_TEMP, 16'h2000);
    rd(REG_CONTROL, 16'h003c);
    rd(REG_STATUS, 16'h0043);
    rd(REG_STATUS, 16'h0000);
    wr(REG_CONTROL, 16'h0038);
    chkb(pin_oe, 1'b1);
    host_u.xfer(GCS_KIND_ARA, 4'h0, 16'h0, q);
    chkb(pin_oe, 1'b0);
    wr(REG_THR_BASE + 4'h2, 16'hffff);
    wr(REG_THR_BASE + 4'h5, 16'h0000);
  endtask
  task automatic t_auto();
    int n;
    wr(REG_CONTROL, 16'h00fc);
    wrun(1'b1, n);
    n = 0;
    while (adc_sel !== SEL_TEMP && n < 200) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    while (adc_sel === SEL_TEMP && n < 400) begin
      @(posedge core_clk);
      #2;
      n++;
    end
    chk({14'h0, adc_sel}, {14'h0, SEL_VOLT});
    chkb(adc_run, 1'b1);
    wr(REG_CONTROL, 16'h003c);
    chkb(adc_run, 1'b1);
    wrun(1'b0, n);
    repeat (100) @(posedge core_clk);
    chkb(adc_run, 1'b0);
  endtask
  task automatic t_scan();
    int n;
    wr(REG_CONTROL, 16'h00bc);
    wrun(1'b1, n);
    wrun(1'b0, n);
    wrun(1'b1, n);
    chkb(n >= IC - 1 && n <= IC + 3, 1'b1);
    wr(REG_CONTROL, 16'h003c);
    wrun(1'b0, n);
  endtask
  task automatic t_charge();
    wr(REG_CONTROL, 16'h003a);
    host_u.charger(1'b1);
    repeat (10) @(posedge core_clk);
    host_u.charger(1'b0);
    rd(REG_ACC, 16'hffff);
    wr(REG_CONTROL, 16'h0039);
    chkb(analog_shdn, 1'b1);
    wr(REG_ACC, 16'h1234);
    host_u.charger(1'b1);
    repeat (10) @(posedge core_clk);
    rd(REG_ACC, 16'h1234);
    chkb(pin_oe, 1'b0);
    host_u.charger(1'b0);
  endtask
  task automatic t_prescale();
    wr(REG_CONTROL, 16'h0001);
    pulse(1'b1, 2);
    rd(REG_ACC, 16'h1234);
    wr(REG_CONTROL, 16'h0008);
    pulse(1'b1, 3);
    rd(REG_ACC, 16'h1234);
    wr(REG_CONTROL, 16'h0009);
    wr(REG_CONTROL, 16'h0008);
    pulse(1'b1, 1);
    rd(REG_ACC, 16'h1234);
    pulse(1'b1, 3);
    rd(REG_ACC, 16'h1235);
    rd(REG_CONTROL, 16'h0008);
    wr(REG_CONTROL, 16'h0000);
    pulse(1'b0, 1);
    rd(REG_ACC, 16'h1234);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    adc_result = 16'h0;
    chg_up_pin = 1'b0;
    chg_dn_pin = 1'b0;
    // Long enough for at least two link clock rising edges as well
    repeat (8) @(posedge core_clk);
    #2;
    rst_n = 1'b1;
    repeat (5) @(posedge link_clk);
    t_reset();
    t_manual();
    t_auto();
    t_scan();
    t_charge();
    t_prescale();
    chkb(hung, 1'b0);
    wrap_up();
  end
  initial begin
    #3000000;
    miscompares++;
    wrap_up();
  end
endmodule  // tb_top
`default_nettype wire
